// file: rtl/gpio_cfg_pkg.sv
/*
  Constants for the four-pin general-purpose port that sits in one
  configuration register word of the bridge.
  Assumes a configuration-cycle decoder outside that gives one-cycle
  read and write strobes with a byte address and byte enables.
*/
package gpio_cfg_pkg;

  localparam int          PIN_COUNT      = 4;
  localparam logic [7:0]  GPIO_CTRL_OFS  = 8'h64;
  localparam int          OUT_CLR_LSB    = 8;
  localparam int          OUT_SET_LSB    = 12;
  localparam int          OE_CLR_LSB     = 16;
  localparam int          OE_SET_LSB     = 20;
  localparam int          RSVD_LSB       = 24;
  localparam int          IN_LSB         = 28;
  localparam int          OUT_LANE       = 1;
  localparam int          OE_LANE        = 2;
  localparam logic [3:0]  NIBBLE_RESET   = 4'h0;
  localparam logic [31:0] WORD_ZERO      = 32'h0000_0000;

  // Picks one four-bit field out of a data word
  function automatic logic [3:0] field4(input logic [31:0] word,
                                        input int          lsb);
    field4 = word[lsb +: 4];
  endfunction : field4

  // Word address match; the low two byte-address bits do not select
  function automatic logic word_hit(input logic [7:0] addr);
    word_hit = (addr[7:2] == GPIO_CTRL_OFS[7:2]);
  endfunction : word_hit

endpackage : gpio_cfg_pkg

// file: rtl/gpio_cfg_port.sv
/*
  Four-pin general-purpose port in one configuration register word.
  Assumes configuration writes and reads arrive as one-cycle strobes
  with byte address, byte enables and data; the bridge answers reads
  from CFG_RDATA_O one cycle later, marked by CFG_RACK_O.
  Byte lane 0 of the word belongs to other bridge logic and reads zero.
*/
`timescale 1ns/10ps
`default_nettype none
module gpio_cfg_port
  import gpio_cfg_pkg::*;
(
  input  wire logic        REF_CLK_I,
  input  wire logic        RESETN_I,
  input  wire logic        CFG_WR_I,
  input  wire logic        CFG_RD_I,
  input  wire logic [7:0]  CFG_ADDR_I,
  input  wire logic [3:0]  CFG_BE_I,
  input  wire logic [31:0] CFG_WDATA_I,
  output logic      [31:0] CFG_RDATA_O,
  output logic             CFG_RACK_O,
  input  wire logic [3:0]  GPIO_IN_I,
  output logic      [3:0]  GPIO_OUT_O,
  output logic      [3:0]  GPIO_OE_O
);

  typedef struct packed {
    logic [31:0] rdata;
    logic        rack;
  } bus_t;

  bus_t bus_reg;
  bus_t bus_next;

  logic       wr_out;
  logic       wr_oe;
  logic       rd_hit;
  logic [3:0] out_set;
  logic [3:0] out_clr;
  logic [3:0] oe_set;
  logic [3:0] oe_clr;
  logic [3:0] data_state;
  logic [3:0] oe_state;
  logic [3:0] out_set_last;
  logic [3:0] out_clr_last;
  logic [3:0] oe_set_last;
  logic [3:0] oe_clr_last;
  logic [3:0] in_state;
  logic [3:0] clr_mask;
  logic [3:0] set_mask;
  logic [3:0] oe_on_mask;
  logic [3:0] oe_off_mask;
  logic [3:0] oe_both_mask;
  logic [3:0] out_both_mask;

  // Each byte lane writes only its own pair; reserved lane is ignored
  assign wr_out  = CFG_WR_I && word_hit(CFG_ADDR_I) && CFG_BE_I[OUT_LANE];
  assign wr_oe   = CFG_WR_I && word_hit(CFG_ADDR_I) && CFG_BE_I[OE_LANE];
  assign rd_hit  = CFG_RD_I && word_hit(CFG_ADDR_I);
  assign out_set = field4(CFG_WDATA_I, OUT_SET_LSB);
  assign out_clr = field4(CFG_WDATA_I, OUT_CLR_LSB);
  assign oe_set  = field4(CFG_WDATA_I, OE_SET_LSB);
  assign oe_clr  = field4(CFG_WDATA_I, OE_CLR_LSB);

  // Data bits move only on pins already bidirectional before the write
  gpio_w1_field u_out_field (
    .clk_i      (REF_CLK_I),
    .rst_n_i    (RESETN_I),
    .wr_i       (wr_out),
    .set_i      (out_set),
    .clr_i      (out_clr),
    .allow_i    (oe_state),
    .state_o    (data_state),
    .set_last_o (out_set_last),
    .clr_last_o (out_clr_last)
  );

  gpio_w1_field u_oe_field (
    .clk_i      (REF_CLK_I),
    .rst_n_i    (RESETN_I),
    .wr_i       (wr_oe),
    .set_i      (oe_set),
    .clr_i      (oe_clr),
    .allow_i    (4'hF),
    .state_o    (oe_state),
    .set_last_o (oe_set_last),
    .clr_last_o (oe_clr_last)
  );

  gpio_pin_io u_pins (
    .clk_i   (REF_CLK_I),
    .rst_n_i (RESETN_I),
    .data_i  (data_state),
    .oe_i    (oe_state),
    .pins_i  (GPIO_IN_I),
    .out_o   (GPIO_OUT_O),
    .oe_o    (GPIO_OE_O),
    .in_o    (in_state)
  );

  always_comb begin
    bus_next       = bus_reg;
    bus_next.rack  = rd_hit;
    bus_next.rdata = WORD_ZERO;
    if (rd_hit) begin
      bus_next.rdata[OUT_CLR_LSB +: 4] = out_clr_last;
      bus_next.rdata[OUT_SET_LSB +: 4] = out_set_last;
      bus_next.rdata[OE_CLR_LSB +: 4]  = oe_clr_last;
      bus_next.rdata[OE_SET_LSB +: 4]  = oe_set_last;
      bus_next.rdata[RSVD_LSB +: 4]    = NIBBLE_RESET;
      bus_next.rdata[IN_LSB +: 4]      = in_state;
    end
  end

  always_ff @(posedge REF_CLK_I) begin
    if (!RESETN_I) begin
      bus_reg <= '{WORD_ZERO, 1'b0};
    end else begin
      bus_reg <= bus_next;
    end
  end

  assign CFG_RDATA_O = bus_reg.rdata;
  assign CFG_RACK_O  = bus_reg.rack;

  // Helper masks seen only by the checks below
  assign clr_mask = wr_out ? (out_clr & oe_state) : 4'h0;
  assign set_mask = wr_out ? (out_set & ~out_clr & oe_state) : 4'h0;
  assign oe_on_mask    = wr_oe ? (oe_set & ~oe_clr) : 4'h0;
  assign oe_off_mask   = wr_oe ? oe_clr : 4'h0;
  assign oe_both_mask  = wr_oe ? (oe_set & oe_clr) : 4'h0;
  assign out_both_mask = wr_out ? (out_set & out_clr & oe_state) : 4'h0;

  AST_CLR_LOW: assert property (@(posedge REF_CLK_I)
    disable iff (!RESETN_I)
    (clr_mask != 4'h0) |-> ##2 ((GPIO_OUT_O & $past(clr_mask, 2)) == 4'h0))
    else $error("clear write did not drive pin low");

  AST_SET_HIGH: assert property (@(posedge REF_CLK_I)
    disable iff (!RESETN_I)
    (set_mask != 4'h0) |-> ##2
      ((GPIO_OUT_O & $past(set_mask, 2)) == $past(set_mask, 2)))
    else $error("set write did not drive pin high");

  AST_OUT_NEXT_CYCLE: assert property (@(posedge REF_CLK_I)
    disable iff (!RESETN_I)
    1'b1 |=> (GPIO_OUT_O == $past(data_state)
              && GPIO_OE_O == $past(oe_state)))
    else $error("pin did not follow state one cycle later");

  AST_INPUT_ONLY_KEPT: assert property (@(posedge REF_CLK_I)
    disable iff (!RESETN_I)
    wr_out |=> ((data_state & ~$past(oe_state))
                == ($past(data_state) & ~$past(oe_state))))
    else $error("data moved on an input-only pin");

  AST_READ_LAST: assert property (@(posedge REF_CLK_I)
    disable iff (!RESETN_I)
    (wr_out && CFG_BE_I[OE_LANE]) ##1 rd_hit |=>
      (CFG_RDATA_O[23:8] == $past(CFG_WDATA_I[23:8], 2)))
    else $error("readback differs from last written value");

  AST_OE_CLEARED: assert property (@(posedge REF_CLK_I)
    disable iff (!RESETN_I)
    wr_oe |=> ((oe_state & $past(oe_clr)) == 4'h0))
    else $error("enable clear left a driver on");

  AST_OE_SET: assert property (@(posedge REF_CLK_I)
    disable iff (!RESETN_I)
    wr_oe |=> ((oe_state & $past(oe_on_mask))
               == $past(oe_on_mask)))
    else $error("enable set did not turn driver on");

  AST_RESET_ZERO: assert property (@(posedge REF_CLK_I)
    disable iff (!RESETN_I)
    $rose(RESETN_I) |-> (oe_state == 4'h0 && data_state == 4'h0
                         && oe_set_last == 4'h0 && out_clr_last == 4'h0))
    else $error("port state not zero after reset");

  AST_INPUT_READ: assert property (@(posedge REF_CLK_I)
    disable iff (!RESETN_I)
    rd_hit |=> (CFG_RDATA_O[IN_LSB +: 4] == $past(in_state)))
    else $error("input field does not show sampled pins");

  AST_RSVD_ZERO: assert property (@(posedge REF_CLK_I)
    disable iff (!RESETN_I)
    CFG_RACK_O |-> (CFG_RDATA_O[27:24] == 4'h0
                    && CFG_RDATA_O[7:0] == 8'h00))
    else $error("reserved bits read nonzero");

  AST_CLR_WINS: assert property (@(posedge REF_CLK_I)
    disable iff (!RESETN_I)
    wr_oe |=> ((oe_state & $past(oe_both_mask)) == 4'h0))
    else $error("set beat clear in the same write");

  AST_OUT_CLR_WINS: assert property (@(posedge REF_CLK_I)
    disable iff (!RESETN_I)
    wr_out
      |=> ((data_state & $past(out_both_mask)) == 4'h0))
    else $error("data set beat clear in the same write");

  AST_RACK_FOLLOWS_READ: assert property (@(posedge REF_CLK_I)
    disable iff (!RESETN_I)
    1'b1
      |=> (CFG_RACK_O == $past(rd_hit)))
    else $error("read answer not one cycle after a hit read");

  AST_MISS_READ_SILENT: assert property (@(posedge REF_CLK_I)
    disable iff (!RESETN_I)
    (CFG_RD_I && !word_hit(CFG_ADDR_I))
      |=> !CFG_RACK_O)
    else $error("read of another word was answered");

  // Idle read bus stays zero so a wired-or return path is safe
  AST_RDATA_IDLE_ZERO: assert property (@(posedge REF_CLK_I)
    disable iff (!RESETN_I)
    !CFG_RACK_O
      |-> (CFG_RDATA_O == WORD_ZERO))
    else $error("read data nonzero without an answer");

  AST_MISS_WRITE_KEEPS: assert property (@(posedge REF_CLK_I)
    disable iff (!RESETN_I)
    (CFG_WR_I && !word_hit(CFG_ADDR_I))
      |=> ($stable(data_state) && $stable(oe_state)))
    else $error("write to another word moved port state");

  AST_DATA_ONLY_BY_WRITE: assert property (@(posedge REF_CLK_I)
    disable iff (!RESETN_I)
    !wr_out
      |=> $stable(data_state))
    else $error("data moved without a data-lane write");

  AST_OE_ONLY_BY_WRITE: assert property (@(posedge REF_CLK_I)
    disable iff (!RESETN_I)
    !wr_oe
      |=> $stable(oe_state))
    else $error("enable moved without an enable-lane write");

  AST_OE_ZERO_KEEPS: assert property (@(posedge REF_CLK_I)
    disable iff (!RESETN_I)
    (wr_oe && oe_set == 4'h0 && oe_clr == 4'h0)
      |=> $stable(oe_state))
    else $error("zero enable write changed the enables");

  AST_READ_OUT_FIELDS: assert property (@(posedge REF_CLK_I)
    disable iff (!RESETN_I)
    wr_out ##1 rd_hit
      |=> (CFG_RDATA_O[15:8] == $past(CFG_WDATA_I[15:8], 2)))
    else $error("data fields do not read back last write");

  AST_READ_OE_FIELDS: assert property (@(posedge REF_CLK_I)
    disable iff (!RESETN_I)
    wr_oe ##1 rd_hit
      |=> (CFG_RDATA_O[23:16] == $past(CFG_WDATA_I[23:16], 2)))
    else $error("enable fields do not read back last write");

  AST_OE_PIN_OFF: assert property (@(posedge REF_CLK_I)
    disable iff (!RESETN_I)
    (oe_off_mask != 4'h0)
      |-> ##2 ((GPIO_OE_O & $past(oe_off_mask, 2)) == 4'h0))
    else $error("enable clear did not release the pin");

  AST_OE_PIN_ON: assert property (@(posedge REF_CLK_I)
    disable iff (!RESETN_I)
    (oe_on_mask != 4'h0)
      |-> ##2 ((GPIO_OE_O & $past(oe_on_mask, 2))
               == $past(oe_on_mask, 2)))
    else $error("enable set did not drive the pin");

  AST_IN_PIN_NEXT: assert property (@(posedge REF_CLK_I)
    disable iff (!RESETN_I)
    $past(RESETN_I)
      |-> (in_state == $past(GPIO_IN_I)))
    else $error("input field lags the pins");

  AST_PINS_IDLE_AFTER_RESET: assert property (@(posedge REF_CLK_I)
    disable iff (!RESETN_I)
    $rose(RESETN_I)
      |-> (GPIO_OE_O == 4'h0 && GPIO_OUT_O == 4'h0))
    else $error("pins driven right after reset");

  COV_ENABLE_THEN_SET: cover property (@(posedge REF_CLK_I)
    disable iff (!RESETN_I)
    (wr_oe && oe_set != 4'h0) ##[1:10] (set_mask != 4'h0));

  COV_CLR_DRIVES: cover property (@(posedge REF_CLK_I)
    disable iff (!RESETN_I)
    (clr_mask != 4'h0) ##2 (GPIO_OE_O != 4'h0));

  COV_READ: cover property (@(posedge REF_CLK_I)
    disable iff (!RESETN_I)
    rd_hit ##1 (CFG_RDATA_O[IN_LSB +: 4] != 4'h0));

  COV_WRITE_THEN_READ: cover property (@(posedge REF_CLK_I)
    disable iff (!RESETN_I)
    (wr_out && CFG_BE_I[OE_LANE]) ##1 rd_hit);

  COV_ENABLE_BOTH: cover property (@(posedge REF_CLK_I)
    disable iff (!RESETN_I)
    (oe_both_mask != 4'h0) ##2 (GPIO_OE_O != 4'h0));

endmodule : gpio_cfg_port
`default_nettype wire

// file: rtl/gpio_pin_io.sv
/*
  Pin stage: registered drive value and enable, and the input sampler.
  Assumes the pins are synchronous to the clock, so one flop suffices.
*/
`timescale 1ns/10ps
`default_nettype none
module gpio_pin_io
  import gpio_cfg_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [3:0] data_i,
  input  wire logic [3:0] oe_i,
  input  wire logic [3:0] pins_i,
  output logic      [3:0] out_o,
  output logic      [3:0] oe_o,
  output logic      [3:0] in_o
);

  typedef struct packed {
    logic [3:0] out;
    logic [3:0] oe;
    logic [3:0] in;
  } pin_t;

  pin_t pin_reg;
  pin_t pin_next;

  always_comb begin
    pin_next     = pin_reg;
    pin_next.out = data_i;
    pin_next.oe  = oe_i;
    pin_next.in  = pins_i;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pin_reg <= '{NIBBLE_RESET, NIBBLE_RESET, NIBBLE_RESET};
    end else begin
      pin_reg <= pin_next;
    end
  end

  assign out_o = pin_reg.out;
  assign oe_o  = pin_reg.oe;
  assign in_o  = pin_reg.in;

  AST_INPUT_FOLLOWS: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    $past(rst_n_i) |-> (in_o == $past(pins_i)))
    else $error("input sample missed a pin change");

endmodule : gpio_pin_io
`default_nettype wire

// file: rtl/gpio_w1_field.sv
/*
  One write-one-to-set / write-one-to-clear pair with the state it
  steers and the last value written to each half.
  Assumes wr_i is a one-cycle strobe already qualified by its byte lane.
*/
`timescale 1ns/10ps
`default_nettype none
module gpio_w1_field
  import gpio_cfg_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  input  wire logic       wr_i,
  input  wire logic [3:0] set_i,
  input  wire logic [3:0] clr_i,
  input  wire logic [3:0] allow_i,
  output logic      [3:0] state_o,
  output logic      [3:0] set_last_o,
  output logic      [3:0] clr_last_o
);

  typedef struct packed {
    logic [3:0] state;
    logic [3:0] set_last;
    logic [3:0] clr_last;
  } field_t;

  field_t st_reg;
  field_t st_next;

  always_comb begin
    st_next = st_reg;
    if (wr_i) begin
      // Clear applied after set so it wins on the same bit
      st_next.state    = (st_reg.state | (set_i & allow_i))
                         & ~(clr_i & allow_i);
      st_next.set_last = set_i;
      st_next.clr_last = clr_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      st_reg <= '{NIBBLE_RESET, NIBBLE_RESET, NIBBLE_RESET};
    end else begin
      st_reg <= st_next;
    end
  end

  assign state_o    = st_reg.state;
  assign set_last_o = st_reg.set_last;
  assign clr_last_o = st_reg.clr_last;

  AST_FIELD_ZERO_KEEPS: assert property (@(posedge clk_i)
    disable iff (!rst_n_i)
    (wr_i && set_i == 4'h0 && clr_i == 4'h0) |=> $stable(st_reg.state))
    else $error("zero write changed field state");

endmodule : gpio_w1_field
`default_nettype wire

// file: test/gpio_board_model.sv
/*
  Board-side model of the four general-purpose pins.
  Assumes the port drive and enable are registered on the bench clock;
  pins that the port does not drive follow the board level.
*/
`timescale 1ns/10ps
`default_nettype none
module gpio_board_model (
  input  wire logic [3:0] drive_i,
  input  wire logic [3:0] oe_i,
  input  wire logic [3:0] ext_i,
  output logic      [3:0] level_o
);
  // Wire level seen by the sampler, chosen by the port's enable alone
  assign level_o = (oe_i & drive_i) | (~oe_i & ext_i);
endmodule : gpio_board_model
`default_nettype wire

// file: test/tb_top.sv
/*
  Self-checking bench for the configuration-word pin port.
  Assumes one-cycle write and read strobes and a read answer one cycle
  after the read edge, with pins modelled by the board model.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import gpio_cfg_pkg::*;
  logic        ref_clk   = 1'b0;
  logic        resetn    = 1'b0;
  logic        cfg_wr    = 1'b0;
  logic        cfg_rd    = 1'b0;
  logic [7:0]  cfg_addr  = 8'h00;
  logic [3:0]  cfg_be    = 4'h0;
  logic [31:0] cfg_wdata = 32'h0000_0000;
  logic [31:0] cfg_rdata;
  logic        cfg_rack;
  logic [3:0]  gpio_in;
  logic [3:0]  gpio_out;
  logic [3:0]  gpio_oe;
  logic [3:0]  ext       = 4'hA;
  logic [7:0]  lane1     = 8'h00;
  logic [7:0]  lane2     = 8'h00;
  int          err_total = 0;
  int          tests_run = 0;

  always #5 ref_clk = ~ref_clk;

  gpio_cfg_port uut (
    .REF_CLK_I(ref_clk), .RESETN_I(resetn), .CFG_WR_I(cfg_wr),
    .CFG_RD_I(cfg_rd), .CFG_ADDR_I(cfg_addr), .CFG_BE_I(cfg_be),
    .CFG_WDATA_I(cfg_wdata), .CFG_RDATA_O(cfg_rdata),
    .CFG_RACK_O(cfg_rack), .GPIO_IN_I(gpio_in),
    .GPIO_OUT_O(gpio_out), .GPIO_OE_O(gpio_oe)
  );

  gpio_board_model board (
    .drive_i(gpio_out), .oe_i(gpio_oe), .ext_i(ext), .level_o(gpio_in)
  );

  task automatic close_out;
    $display("mismatches %0d comparisons %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : close_out

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Expected word: only the lanes the last hit write touched move
  function automatic logic [31:0] word(input logic [3:0] pins);
    word = {pins, 4'h0, lane2, lane1, 8'h00};
  endfunction : word

  task automatic wr(input logic [31:0] d, input logic [3:0] be = 4'h6,
                    input logic [7:0] a = GPIO_CTRL_OFS);
    @(posedge ref_clk);
    cfg_wr    <= 1'b1;
    cfg_addr  <= a;
    cfg_be    <= be;
    cfg_wdata <= d;
    @(posedge ref_clk);
    cfg_wr    <= 1'b0;
    if (a[7:2] == GPIO_CTRL_OFS[7:2] && be[1])
      lane1 = d[15:8];
    if (a[7:2] == GPIO_CTRL_OFS[7:2] && be[2])
      lane2 = d[23:16];
  endtask : wr

  // Answer is fixed at one cycle after the read edge
  task automatic rd(input logic [7:0] a, input logic ack,
                    input logic [31:0] exp);
    @(posedge ref_clk);
    cfg_rd   <= 1'b1;
    cfg_addr <= a;
    @(posedge ref_clk);
    cfg_rd   <= 1'b0;
    #1;
    check({31'h0, cfg_rack}, {31'h0, ack});
    check(cfg_rdata, exp);
  endtask : rd

  // Disabled pins are masked: their drive value is not visible
  task automatic pins(input logic [3:0] oe, input logic [3:0] out);
    check({24'h0, gpio_oe, gpio_out & gpio_oe}, {24'h0, oe, out});
  endtask : pins

  // Waits out the pin flop after a write before judging the pins
  task automatic settle(input logic [3:0] oe, input logic [3:0] out);
    @(posedge ref_clk);
    #1;
    pins(oe, out);
  endtask : settle

  task automatic t_reset;
    pins(4'h0, 4'h0);
    rd(GPIO_CTRL_OFS, 1'b1, word(4'hA));
  endtask : t_reset

  task automatic t_input_only;
    wr(32'h0000_F000);
    settle(4'h0, 4'h0);
    rd(8'h66, 1'b1, word(4'hA));
  endtask : t_input_only

  task automatic t_drive;
    wr(32'h00F0_0000);
    settle(4'hF, 4'h0);
    wr(32'h0000_5000);
    #1;
    pins(4'hF, 4'h0);
    settle(4'hF, 4'h5);
    rd(GPIO_CTRL_OFS, 1'b1, word(4'h5));
    wr(32'h0000_0100);
    settle(4'hF, 4'h4);
    wr(32'h0000_4400);
    settle(4'hF, 4'h0);
    wr(32'h0000_3000);
    wr(32'h0011_0000);
    settle(4'hE, 4'h2);
  endtask : t_drive

  task automatic t_oe_clear;
    wr(32'h0002_0000);
    settle(4'hC, 4'h0);
    wr(32'h0000_0200);
    wr(32'h0020_0000);
    settle(4'hE, 4'h2);
  endtask : t_oe_clear

  task automatic t_input_follow;
    wr(32'h000F_0000);
    settle(4'h0, 4'h0);
    @(posedge ref_clk);
    ext <= 4'h3;
    rd(GPIO_CTRL_OFS, 1'b1, word(4'h3));
  endtask : t_input_follow

  task automatic t_reserved;
    wr(32'h0F00_00FF, 4'hF);
    wr(32'h00FF_FF00, 4'h9);
    rd(8'h67, 1'b1, word(4'h3));
    wr(32'h00F0_0000, 4'h6, 8'h68);
    settle(4'h0, 4'h0);
    rd(8'h68, 1'b0, 32'h0000_0000);
  endtask : t_reserved

  // Write then read on the very next edge, as the bus allows
  task automatic t_back_to_back;
    @(posedge ref_clk);
    cfg_wr    <= 1'b1;
    cfg_addr  <= GPIO_CTRL_OFS;
    cfg_be    <= 4'h6;
    cfg_wdata <= 32'h0050_A000;
    @(posedge ref_clk);
    cfg_wr    <= 1'b0;
    cfg_rd    <= 1'b1;
    lane1 = 8'hA0;
    lane2 = 8'h50;
    @(posedge ref_clk);
    cfg_rd    <= 1'b0;
    #1;
    check(cfg_rdata, word(4'h3));
    pins(4'h5, 4'h1);
  endtask : t_back_to_back

  task automatic t_midrun_reset;
    @(posedge ref_clk);
    resetn <= 1'b0;
    ext    <= 4'hA;
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    lane1 = 8'h00;
    lane2 = 8'h00;
    @(posedge ref_clk);
    #1;
    t_reset();
  endtask : t_midrun_reset

  // Hang guard well past the longest sequence
  initial begin
    repeat (5000) @(posedge ref_clk);
    err_total++;
    close_out();
  end

  initial begin
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    #1;
    t_reset();
    t_input_only();
    t_drive();
    t_oe_clear();
    t_input_follow();
    t_reserved();
    t_back_to_back();
    t_midrun_reset();
    close_out();
  end
endmodule : tb_top
`default_nettype wire
